// *** design/ast_transceiver.sv ***
module ast_transceiver
    import ast_pkg::*;
(
    input wire logic i_sys_clk,
    input wire logic i_rst,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    input wire logic i_rxd,
    output logic o_txd,
    output logic o_txd_oe
);
    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        logic armed;
        logic [8:0] rx_buf;
        logic rx_buffer_full;
        logic ovr;
        logic fe;
        logic nf;
        logic tx_buffer_empty;
        logic tc;
        logic [7:0] tx_buf;
        logic te;
        logic re;
        logic send_break;
        logic nine;
        logic lbrk;
        logic tx_polarity_invert;
        logic rx_polarity_invert;
        logic t8;
        logic [15:0] divisor;
        logic [3:0] tx_sub;
        logic tx_busy;
        logic tx_brk;
        logic [10:0] shreg;
        logic [3:0] tx_cnt;
        logic idle_q;
        logic brk_q;
        logic txd;
        logic txd_oe;
    } ast_top_state_type;

    ast_top_state_type r, n;

    logic tick16;
    logic rx_done;
    logic [8:0] rx_data;
    logic rx_stop_ok;
    logic rx_noise;

    ast_baud_gen u_baud (
        .i_sys_clk(i_sys_clk),
        .i_rst(i_rst),
        .i_divisor(r.divisor),
        .o_tick16(tick16)
    );

    ast_receiver u_rx (
        .i_sys_clk(i_sys_clk),
        .i_rst(i_rst),
        .i_tick16(tick16),
        .i_rxd(i_rxd),
        .i_rx_enable(r.re),
        .i_rx_invert(r.rx_polarity_invert),
        .i_nine_bit(r.nine),
        .o_done(rx_done),
        .o_data(rx_data),
        .o_stop_ok(rx_stop_ok),
        .o_noise(rx_noise)
    );

    function automatic logic ast_mapped(input logic [7:0] a);
        return a == AST_OFS_DATA || a == AST_OFS_STATUS || a == AST_OFS_CTRL
            || a == AST_OFS_CONFIG || a == AST_OFS_BAUD;
    endfunction : ast_mapped

    always_comb begin
        logic setup;
        logic acc;
        logic bit_tick;
        logic free;
        logic [31:0] rd;
        logic [3:0] flen;
        setup = i_psel & ~i_penable;
        acc = i_psel & i_penable & r.pready;
        bit_tick = tick16 && r.tx_sub == 4'hF;
        free = 1'b0;
        rd = 32'h0000_0000;
        flen = r.nine ? AST_FRAME_9 : AST_FRAME_8;
        n = r;
        n.pready = 1'b0;
        n.pslverr = 1'b0;

        unique case (i_paddr)
            AST_OFS_DATA: rd[7:0] = r.rx_buf[7:0];
            AST_OFS_STATUS: begin
                rd[AST_ST_TX_BUFFER_EMPTY] = r.tx_buffer_empty;
                rd[AST_ST_TC] = r.tc;
                rd[AST_ST_RX_BUFFER_FULL] = r.rx_buffer_full;
                rd[AST_ST_OVR] = r.ovr;
                rd[AST_ST_FE] = r.fe;
                rd[AST_ST_NF] = r.nf;
                rd[AST_ST_R8] = r.rx_buf[8];
            end
            AST_OFS_CTRL: begin
                rd[AST_CT_TE] = r.te;
                rd[AST_CT_RE] = r.re;
                rd[AST_CT_SBK] = r.send_break;
            end
            AST_OFS_CONFIG: begin
                rd[AST_CF_NINE] = r.nine;
                rd[AST_CF_LBRK] = r.lbrk;
                rd[AST_CF_TX_POLARITY_INVERT] = r.tx_polarity_invert;
                rd[AST_CF_RX_POLARITY_INVERT] = r.rx_polarity_invert;
                rd[AST_CF_T8] = r.t8;
            end
            AST_OFS_BAUD: rd[15:0] = r.divisor;
            default: rd = 32'h0000_0000;
        endcase

        // Zero wait states: pready rises for the first access cycle
        if (setup) begin
            n.pready = 1'b1;
            n.pslverr = ~ast_mapped(i_paddr);
            n.prdata = rd;
        end

        if (acc && !i_pwrite) begin
            // Arm on the flags the host actually saw
            if (i_paddr == AST_OFS_STATUS) begin
                n.armed = r.prdata[AST_ST_RX_BUFFER_FULL] | r.prdata[AST_ST_OVR] | r.prdata[AST_ST_FE];
            end else if (i_paddr == AST_OFS_DATA && r.armed) begin
                n.rx_buffer_full = 1'b0;
                n.ovr = 1'b0;
                n.fe = 1'b0;
                n.nf = 1'b0;
                n.armed = 1'b0;
            end
        end

        if (acc && i_pwrite) begin
            unique case (i_paddr)
                AST_OFS_DATA: begin
                    n.tx_buf = i_pwdata[7:0];
                    n.tx_buffer_empty = 1'b0;
                    n.tc = 1'b0;
                end
                AST_OFS_CTRL: begin
                    n.te = i_pwdata[AST_CT_TE];
                    n.re = i_pwdata[AST_CT_RE];
                    n.send_break = i_pwdata[AST_CT_SBK];
                    if (i_pwdata[AST_CT_TE] && !r.te) begin
                        n.idle_q = 1'b1;
                        n.tc = 1'b0;
                    end
                    if (r.send_break && !i_pwdata[AST_CT_SBK]) begin
                        n.brk_q = 1'b1;
                        n.tc = 1'b0;
                    end
                end
                AST_OFS_CONFIG: begin
                    n.nine = i_pwdata[AST_CF_NINE];
                    n.lbrk = i_pwdata[AST_CF_LBRK];
                    n.tx_polarity_invert = i_pwdata[AST_CF_TX_POLARITY_INVERT];
                    n.rx_polarity_invert = i_pwdata[AST_CF_RX_POLARITY_INVERT];
                    n.t8 = i_pwdata[AST_CF_T8];
                end
                AST_OFS_BAUD: n.divisor = i_pwdata[15:0];
                default: n.divisor = r.divisor;
            endcase
        end

        // Receive completion after host clears, so a set wins
        if (rx_done && !n.fe) begin
            if (!rx_stop_ok) begin
                n.fe = 1'b1;
            end else if (n.rx_buffer_full) begin
                n.ovr = 1'b1;
            end else begin
                n.rx_buf = rx_data;
                n.rx_buffer_full = 1'b1;
                n.nf = rx_noise;
            end
        end

        // Transmitter: one bit per sixteen sample ticks
        if (tick16) begin
            n.tx_sub = r.tx_sub + 4'h1;
        end
        if (bit_tick) begin
            if (r.tx_busy) begin
                n.shreg = {~r.tx_brk, r.shreg[10:1]};
                n.tx_cnt = r.tx_cnt - 4'h1;
                free = r.tx_cnt == 4'h1;
            end else begin
                free = 1'b1;
            end
            if (free) begin
                n.tx_busy = 1'b1;
                n.tx_brk = 1'b0;
                n.tx_cnt = flen;
                if (n.idle_q) begin
                    n.idle_q = 1'b0;
                    n.shreg = '1;
                end else if (n.brk_q) begin
                    n.brk_q = r.send_break;
                    n.tx_brk = 1'b1;
                    n.shreg = '0;
                    if (r.lbrk) begin
                        n.tx_cnt = r.nine ? AST_BRK_9_LONG : AST_BRK_8_LONG;
                    end
                end else if (r.te && !n.tx_buffer_empty) begin
                    // Buffer written in this cycle must not be lost behind stale data
                    n.shreg = {1'b1, r.nine ? r.t8 : 1'b1, n.tx_buf, 1'b0};
                    n.tx_buffer_empty = 1'b1;
                end else begin
                    n.tx_busy = 1'b0;
                    if (r.tx_busy) begin
                        n.tc = 1'b1;
                    end
                end
            end
        end

        n.txd = (n.tx_busy ? n.shreg[0] : 1'b1) ^ n.tx_polarity_invert;
        // Pin held until queued and active frames are done
        n.txd_oe = n.te | n.tx_busy | n.idle_q | n.brk_q;
    end

    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            r <= '{tx_buffer_empty: 1'b1, tc: 1'b1, txd: 1'b1, tx_buf: AST_DATA_RST,
                   divisor: AST_BAUD_RST, default: '0};
        end else begin
            r <= n;
        end
    end

    assign o_prdata = r.prdata;
    assign o_pready = r.pready;
    assign o_pslverr = r.pslverr;
    assign o_txd = r.txd;
    assign o_txd_oe = r.txd_oe;
endmodule : ast_transceiver

// *** design/ast_pkg.sv ***
package ast_pkg;
    // Register byte offsets
    localparam logic [7:0] AST_OFS_DATA = 8'h00;
    localparam logic [7:0] AST_OFS_STATUS = 8'h04;
    localparam logic [7:0] AST_OFS_CTRL = 8'h08;
    localparam logic [7:0] AST_OFS_CONFIG = 8'h0C;
    localparam logic [7:0] AST_OFS_BAUD = 8'h10;
    // status_one_register fields
    localparam int AST_ST_TX_BUFFER_EMPTY = 0;
    localparam int AST_ST_TC = 1;
    localparam int AST_ST_RX_BUFFER_FULL = 2;
    localparam int AST_ST_OVR = 3;
    localparam int AST_ST_FE = 4;
    localparam int AST_ST_NF = 5;
    localparam int AST_ST_R8 = 6;
    // control_two_register fields
    localparam int AST_CT_TE = 0;
    localparam int AST_CT_RE = 1;
    localparam int AST_CT_SBK = 2;
    // Configuration fields
    localparam int AST_CF_NINE = 0;
    localparam int AST_CF_LBRK = 1;
    localparam int AST_CF_TX_POLARITY_INVERT = 2;
    localparam int AST_CF_RX_POLARITY_INVERT = 3;
    localparam int AST_CF_T8 = 4;
    // Reset values
    localparam logic [7:0] AST_DATA_RST = 8'h00;
    localparam logic [15:0] AST_BAUD_RST = 16'h0001;
    // Frame and break lengths in bit times
    localparam logic [3:0] AST_FRAME_8 = 4'hA;
    localparam logic [3:0] AST_FRAME_9 = 4'hB;
    localparam logic [3:0] AST_BRK_8_LONG = 4'hD;
    localparam logic [3:0] AST_BRK_9_LONG = 4'hE;
    // Sample phases, zero based: value k is RT(k+1)
    localparam logic [3:0] AST_RT3 = 4'h2;
    localparam logic [3:0] AST_RT5 = 4'h4;
    localparam logic [3:0] AST_RT7 = 4'h6;
    localparam logic [3:0] AST_RT8 = 4'h7;
    localparam logic [3:0] AST_RT10 = 4'h9;
    localparam logic [3:0] AST_RT11 = 4'hA;
    localparam logic [3:0] AST_RT16 = 4'hF;

    function automatic logic ast_maj3(input logic [2:0] s);
        return (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
    endfunction : ast_maj3
endpackage : ast_pkg

// *** design/ast_baud_gen.sv ***
module ast_baud_gen
    import ast_pkg::*;
(
    input wire logic i_sys_clk,
    input wire logic i_rst,
    input wire logic [15:0] i_divisor,
    output logic o_tick16
);
    typedef struct packed {
        logic [15:0] cnt;
        logic tick;
    } ast_baud_state_type;

    ast_baud_state_type r, n;

    always_comb begin
        n = r;
        n.tick = 1'b0;
        // Divisor zero parks the generator
        if (i_divisor == 16'h0000) begin
            n.cnt = 16'h0000;
        end else if (r.cnt >= i_divisor - 16'h0001) begin
            n.cnt = 16'h0000;
            n.tick = 1'b1;
        end else begin
            n.cnt = r.cnt + 16'h0001;
        end
    end

    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    assign o_tick16 = r.tick;
endmodule : ast_baud_gen

// *** design/ast_receiver.sv ***
module ast_receiver
    import ast_pkg::*;
(
    input wire logic i_sys_clk,
    input wire logic i_rst,
    input wire logic i_tick16,
    input wire logic i_rxd,
    input wire logic i_rx_enable,
    input wire logic i_rx_invert,
    input wire logic i_nine_bit,
    output logic o_done,
    output logic [8:0] o_data,
    output logic o_stop_ok,
    output logic o_noise
);
    typedef enum logic [2:0] {
        AST_RX_IDLE = 3'b001,
        AST_RX_START = 3'b010,
        AST_RX_BITS = 3'b100
    } ast_rx_st_type;

    typedef struct packed {
        logic [1:0] sync;
        ast_rx_st_type st;
        logic [2:0] hist;
        logic [3:0] rt;
        logic [3:0] bitn;
        logic [2:0] smp;
        logic [8:0] shreg;
        logic nz;
        logic done;
        logic [8:0] data;
        logic stop_ok;
        logic noise;
    } ast_rx_state_type;

    ast_rx_state_type r, n;

    always_comb begin
        logic line;
        logic fall;
        logic bend;
        logic b;
        logic [3:0] last;
        line = 1'b0;
        fall = 1'b0;
        bend = 1'b0;
        b = 1'b0;
        last = i_nine_bit ? AST_FRAME_9 - 4'h1 : AST_FRAME_8 - 4'h1;
        n = r;
        n.done = 1'b0;
        n.sync = {r.sync[0], i_rxd};
        line = r.sync[1] ^ i_rx_invert;
        fall = r.hist[0] & ~line;
        if (!i_rx_enable) begin
            n.st = AST_RX_IDLE;
            n.hist = 3'b000;
        end else if (i_tick16) begin
            n.hist = {r.hist[1:0], line};
            n.rt = r.rt + 4'h1;
            unique case (r.st)
                AST_RX_IDLE: begin
                    // Edge means a low after three highs
                    if (!line && r.hist == 3'b111) begin
                        n.st = AST_RX_START;
                        n.rt = 4'h0;
                        n.smp = 3'b000;
                        n.nz = 1'b0;
                    end
                end
                AST_RX_START: begin
                    if (n.rt == AST_RT3 || n.rt == AST_RT5 || n.rt == AST_RT7) begin
                        n.smp = {r.smp[1:0], line};
                    end
                    if (n.rt == AST_RT7) begin
                        n.st = ast_maj3(n.smp) ? AST_RX_IDLE : AST_RX_BITS;
                        n.bitn = 4'h0;
                        n.smp = 3'b000;
                    end
                end
                AST_RX_BITS: begin
                    if (n.rt >= AST_RT8 && n.rt <= AST_RT10) begin
                        n.smp = {r.smp[1:0], line};
                    end
                    // Late edge starts the next bit early
                    if (fall && r.rt >= AST_RT11) begin
                        bend = 1'b1;
                        n.rt = 4'h0;
                    end else if (r.rt == AST_RT16) begin
                        bend = 1'b1;
                    end
                    if (bend) begin
                        b = ast_maj3(r.smp);
                        n.smp = 3'b000;
                        n.bitn = r.bitn + 4'h1;
                        if (r.bitn != 4'h0) begin
                            n.nz = r.nz | (r.smp != 3'b000 && r.smp != 3'b111);
                        end
                        if (r.bitn != 4'h0 && r.bitn != last) begin
                            n.shreg = {b, r.shreg[8:1]};
                        end
                        if (r.bitn == last) begin
                            n.st = AST_RX_IDLE;
                            n.done = 1'b1;
                            n.stop_ok = b;
                            n.noise = n.nz;
                            n.data = i_nine_bit ? r.shreg : {1'b0, r.shreg[8:1]};
                            // Refill so a new start is seen at once, not after a break
                            n.hist = (!b && n.data == 9'h000) ? 3'b000 : 3'b111;
                        end
                    end
                end
                default: n.st = AST_RX_IDLE;
            endcase
        end
    end

    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            r <= '{st: AST_RX_IDLE, default: '0};
        end else begin
            r <= n;
        end
    end

    assign o_done = r.done;
    assign o_data = r.data;
    assign o_stop_ok = r.stop_ok;
    assign o_noise = r.noise;
endmodule : ast_receiver

// *** bench/ast_transceiver_props.sv ***
module ast_transceiver_props (
    input wire logic i_sys_clk,
    input wire logic i_rst,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic [31:0] o_prdata,
    input wire logic o_pready,
    input wire logic o_pslverr,
    input wire logic i_rxd,
    input wire logic o_txd,
    input wire logic o_txd_oe
);
    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (i_rst);
    logic setup;
    assign setup = i_psel && !i_penable;
    property p_rdy_setup;
        setup |=> o_pready;
    endproperty
    a_rdy_setup: assert property (p_rdy_setup) else $error("ready missing");
    property p_rdy_pulse;
        o_pready |=> !o_pready;
    endproperty
    a_rdy_pulse: assert property (p_rdy_pulse) else $error("ready too long");
    property p_err_unmapped;
        setup && i_paddr > 8'h10 |=> o_pready && o_pslverr;
    endproperty
    a_err_unmapped: assert property (p_err_unmapped) else $error("no error");
    property p_ok_mapped;
        setup && i_paddr <= 8'h10 && i_paddr[1:0] == 2'h0 |=> !o_pslverr;
    endproperty
    a_ok_mapped: assert property (p_ok_mapped) else $error("false error");
    property p_err_zero;
        o_pslverr |-> o_pready && o_prdata == 32'h0;
    endproperty
    a_err_zero: assert property (p_err_zero) else $error("error data");
    property p_reset_idle;
        $fell(i_rst) |-> o_txd && !o_txd_oe;
    endproperty
    a_reset_idle: assert property (p_reset_idle) else $error("not idle");
    property p_bit_hold;
        o_txd_oe && $changed(o_txd) |=> $stable(o_txd) [*8];
    endproperty
    a_bit_hold: assert property (p_bit_hold) else $error("short bit");
    property p_preamble;
        $rose(o_txd_oe) |=> $stable(o_txd) [*8];
    endproperty
    a_preamble: assert property (p_preamble) else $error("no preamble");
    c_err: cover property (o_pslverr);
    c_oe_on: cover property ($rose(o_txd_oe));
    c_oe_off: cover property ($fell(o_txd_oe));
endmodule : ast_transceiver_props

bind ast_transceiver ast_transceiver_props i_props (.i_sys_clk(i_sys_clk), .i_rst(i_rst),
    .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
    .i_pwdata(i_pwdata), .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
    .i_rxd(i_rxd), .o_txd(o_txd), .o_txd_oe(o_txd_oe));

// *** bench/ast_serial_peer.sv ***
module ast_serial_peer #(
    parameter int BIT = 16
) (
    input wire logic i_sys_clk,
    input wire logic i_txd,
    input wire logic i_txd_oe,
    output logic o_rxd,
    output logic o_evt,
    output logic [8:0] o_val,
    output logic o_brk,
    output logic [3:0] o_brk_len
);
    timeunit 1ns;
    timeprecision 1ps;
    logic line;
    int low_run = 0;
    // Released pin sits on its pull-up
    assign line = i_txd_oe ? i_txd : 1'b1;
    initial begin
        o_rxd = 1'b1;
        o_evt = 1'b0;
        o_val = 9'h000;
        o_brk = 1'b0;
        o_brk_len = 4'h0;
    end
    task automatic idle(input logic inv);
        o_rxd <= ~inv;
        repeat (BIT) @(posedge i_sys_clk);
    endtask : idle
    task automatic send(input logic [7:0] d, input logic inv, input logic stop);
        logic [9:0] f;
        f = {stop, d, 1'b0};
        for (int i = 0; i < 10; i++) begin
            o_rxd <= f[i] ^ inv;
            repeat (BIT) @(posedge i_sys_clk);
        end
        idle(inv);
    endtask : send
    always begin : decode
        logic [8:0] sh;
        @(posedge i_sys_clk);
        if (line === 1'b0) begin
            repeat (BIT / 2) @(posedge i_sys_clk);
            for (int i = 0; i < 9; i++) begin
                repeat (BIT) @(posedge i_sys_clk);
                sh[i] = line;
            end
            o_evt <= 1'b1;
            o_val <= sh;
            @(posedge i_sys_clk);
            o_evt <= 1'b0;
            while (line !== 1'b1) @(posedge i_sys_clk);
        end
    end
    // 8-bit data frames never hold low for ten bits, so longer runs are breaks
    always @(posedge i_sys_clk) begin
        o_brk <= 1'b0;
        if (line === 1'b0) begin
            low_run <= low_run + 1;
        end else begin
            if (low_run >= 10 * BIT) begin
                o_brk <= 1'b1;
                o_brk_len <= 4'(low_run / BIT);
            end
            low_run <= 0;
        end
    end
endmodule : ast_serial_peer

// *** bench/testbench.sv ***
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import ast_pkg::*;
    logic clk = 1'b0, rst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata;
    logic pready, pslverr, rxd, txd, txd_oe, evt, brk;
    logic [8:0] val;
    logic [3:0] blen;
    logic [64:0] note;
    logic [64:0] exp_rd[$];
    logic [11:0] exp_ser[$];
    int num_errors = 0, samples_checked = 0;
    always #2.5 clk = ~clk;
    ast_transceiver i_ast_transceiver (.i_sys_clk(clk), .i_rst(rst), .i_psel(psel),
        .i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata),
        .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .i_rxd(rxd),
        .o_txd(txd), .o_txd_oe(txd_oe));
    ast_serial_peer #(.BIT(16)) i_ast_serial_peer (.i_sys_clk(clk), .i_txd(txd),
        .i_txd_oe(txd_oe), .o_rxd(rxd), .o_evt(evt), .o_val(val), .o_brk(brk),
        .o_brk_len(blen));
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : check
    task automatic close_out;
        $display("Comparisons %0d, mismatches %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : close_out
    task automatic fail;
        num_errors++;
        $display("MISMATCH at %0t: wait ran out", $time);
        close_out();
    endtask : fail
    // Starts on an edge so two transfers never touch psel in one step
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
            input logic [64:0] n, output logic [31:0] r);
        int k = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        exp_rd.push_back(n);
        @(posedge clk);
        pen <= 1'b1;
        do begin
            @(posedge clk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        r = prdata;
        psel <= 1'b0;
        pen <= 1'b0;
        if (k >= 50) fail();
    endtask : apb
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        apb(1'b1, a, d, 65'h0, r);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] v);
        logic [31:0] r;
        apb(1'b0, a, 32'h0, {1'b0, m, v}, r);
    endtask : rd
    task automatic poll(input int bit_pos);
        logic [31:0] r;
        for (int k = 0; k < 500; k++) begin
            apb(1'b0, AST_OFS_STATUS, 32'h0, 65'h0, r);
            if (r[bit_pos] === 1'b1) return;
        end
        fail();
    endtask : poll
    task automatic drain;
        for (int k = 0; k < 8000; k++) begin
            if (exp_ser.size() == 0) return;
            @(posedge clk);
        end
        fail();
    endtask : drain
    always @(posedge clk) begin
        if (pready === 1'b1) begin
            note = exp_rd.pop_front();
            check({31'h0, pslverr}, {31'h0, note[64]}, "slverr");
            check(prdata & note[63:32], note[31:0], "read data");
        end
        if (evt === 1'b1) check({23'h0, val}, {20'h0, exp_ser.pop_front()}, "char");
        if (brk === 1'b1) check({20'h0, 8'h80, blen}, {20'h0, exp_ser.pop_front()}, "break");
    end
    initial begin
        repeat (60000) @(posedge clk);
        fail();
    end
    initial begin
        logic [31:0] r;
        logic [7:0] b, b2;
        static logic [3:0] lens[4] = '{4'hA, 4'hB, 4'hD, 4'hE};
        r = $urandom(11276);
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        rd(AST_OFS_DATA, 32'hFFFFFFFF, 32'h0);
        rd(AST_OFS_STATUS, 32'hFFFFFFFF, 32'h3);
        rd(AST_OFS_CTRL, 32'hFFFFFFFF, 32'h0);
        rd(AST_OFS_CONFIG, 32'hFFFFFFFF, 32'h0);
        rd(AST_OFS_BAUD, 32'hFFFFFFFF, 32'h1);
        apb(1'b0, 8'h40, 32'h0, {1'b1, 32'hFFFFFFFF, 32'h0}, r);
        check({31'h0, txd}, 32'h1, "idle level");
        wr(AST_OFS_CONFIG, 32'h4);
        repeat (3) @(negedge clk);
        check({31'h0, txd}, 32'h0, "inverted idle");
        wr(AST_OFS_CONFIG, 32'h0);
        $display("registers done");
        wr(AST_OFS_CTRL, 32'h1);
        for (int i = 0; i < 3; i++) begin
            if (i > 0) poll(AST_ST_TX_BUFFER_EMPTY);
            if (i == 2) wr(AST_OFS_CTRL, 32'h0);
            if (i == 2) wr(AST_OFS_CTRL, 32'h1);
            b = 8'($urandom());
            exp_ser.push_back({4'h1, b});
            wr(AST_OFS_DATA, {24'h0, b});
            if (i == 0) rd(AST_OFS_STATUS, 32'h3, 32'h0);
        end
        drain();
        poll(AST_ST_TC);
        b = 8'($urandom());
        exp_ser.push_back({4'h1, b});
        wr(AST_OFS_DATA, {24'h0, b});
        poll(AST_ST_TX_BUFFER_EMPTY);
        wr(AST_OFS_CTRL, 32'h0);
        repeat (3) @(negedge clk);
        check({31'h0, txd_oe}, 32'h1, "pin kept");
        drain();
        repeat (24) @(negedge clk);
        check({31'h0, txd_oe}, 32'h0, "pin released");
        for (int t = 0; t < 2; t++) begin
            wr(AST_OFS_CONFIG, 32'h1 | 32'(t << 4));
            wr(AST_OFS_CTRL, 32'h1);
            b = 8'($urandom()) | 8'h80;
            exp_ser.push_back({3'h0, t[0], b});
            wr(AST_OFS_DATA, {24'h0, b});
            drain();
        end
        for (int k = 0; k < 4; k++) begin
            wr(AST_OFS_CONFIG, 32'(k));
            wr(AST_OFS_CTRL, 32'h5);
            wr(AST_OFS_CTRL, 32'h1);
            exp_ser.push_back(12'h000);
            exp_ser.push_back({8'h80, lens[k]});
            drain();
        end
        wr(AST_OFS_CONFIG, 32'h0);
        $display("transmit done");
        wr(AST_OFS_CTRL, 32'h0);
        i_ast_serial_peer.send(8'($urandom()), 1'b0, 1'b1);
        rd(AST_OFS_STATUS, 32'h4, 32'h0);
        for (int inv = 0; inv < 2; inv++) begin
            wr(AST_OFS_CTRL, 32'h0);
            wr(AST_OFS_CONFIG, 32'(inv << 3));
            // Receiver needs three idle samples while enabled before a start
            wr(AST_OFS_CTRL, 32'h2);
            i_ast_serial_peer.idle(inv[0]);
            b = 8'($urandom());
            i_ast_serial_peer.send(b, inv[0], 1'b1);
            rd(AST_OFS_DATA, 32'hFF, {24'h0, b});
            rd(AST_OFS_STATUS, 32'h3C, 32'h4);
            rd(AST_OFS_DATA, 32'hFF, {24'h0, b});
            rd(AST_OFS_STATUS, 32'h4, 32'h0);
        end
        b = 8'($urandom());
        b2 = ~b;
        i_ast_serial_peer.send(b, 1'b1, 1'b1);
        i_ast_serial_peer.send(b2, 1'b1, 1'b1);
        rd(AST_OFS_STATUS, 32'hC, 32'hC);
        rd(AST_OFS_DATA, 32'hFF, {24'h0, b});
        rd(AST_OFS_STATUS, 32'hC, 32'h0);
        $display("receive done");
        close_out();
    end
endmodule : testbench
